//--- rtl/ewp_pkg.sv
// constants and types shared by the external wake-line and power-mode controller
package ewp_pkg;

  // ==========================================================================
  // register map (word index on the plain register port)
  localparam logic [1:0] ADDR_SENSE   = 2'h0;
  localparam logic [1:0] ADDR_PINSEL  = 2'h1;
  localparam logic [1:0] ADDR_PWRCTRL = 2'h2;
  localparam logic [1:0] ADDR_STATUS  = 2'h3;

  // ==========================================================================
  // values after reset
  localparam logic [7:0] SENSE_RESET   = 8'h00;
  localparam logic [7:0] PINSEL_RESET  = 8'h00;
  localparam logic [1:0] PWRCTRL_RESET = 2'h0;
  localparam logic       IMASK_RESET   = 1'h1;

  // ==========================================================================
  // field positions
  localparam int FIELD_W        = 2;
  localparam int SLOW_SEL_BIT   = 0;
  localparam int AWU_EN_BIT     = 1;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_MASK_BIT  = 3;
  localparam int STAT_REQ_LSB   = 4;

  // ==========================================================================
  // sensitivity and pin-selection codes
  localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
  localparam logic [1:0] SENSE_RISE     = 2'h1;
  localparam logic [1:0] SENSE_FALL     = 2'h2;
  localparam logic [1:0] SENSE_BOTH     = 2'h3;
  localparam logic [1:0] PIN_NONE       = 2'h0;

  // lines 2 and 3 sit on port b, lines 0 and 1 on port a
  localparam logic [3:0] LINE_ON_PORTB = 4'hc;
  // pin bit for codes 1..3 of each line
  localparam logic [2:0] LINE_PIN [4][3] = '{
    '{3'h1, 3'h2, 3'h3},
    '{3'h4, 3'h5, 3'h6},
    '{3'h3, 3'h5, 3'h6},
    '{3'h0, 3'h1, 3'h2}
  };

  // ==========================================================================
  // clock ratios and counts
  localparam int         OSC_DIV_RUN    = 2;
  localparam int         OSC_DIV_SLOW   = 32;
  localparam int         SLOW_RATIO     = OSC_DIV_SLOW / OSC_DIV_RUN;
  localparam logic [4:0] SLOW_LAST      = 5'(SLOW_RATIO - 1);
  localparam int         STARTUP_CYCLES = 256;
  localparam logic [8:0] STARTUP_LAST   = 9'(STARTUP_CYCLES - 1);

  // ==========================================================================
  // power states
  typedef enum logic [2:0] {
    PWR_RUN     = 3'b000,
    PWR_WAIT    = 3'b001,
    PWR_HALT    = 3'b010,
    PWR_STARTUP = 3'b011
  } ewp_state_e;

endpackage : ewp_pkg

//--- rtl/ewp_ext_line.sv
// one external wake line: edge latch plus low-level request
module ewp_ext_line (
  input  wire logic       mclk,
  input  wire logic       rstSync_b,
  input  wire logic       clkEn,
  input  wire logic       lineEn,
  input  wire logic       pinLevel,
  input  wire logic [1:0] senseCode,
  input  wire logic       serviceAck,
  output logic            lineReq
);

  // ==========================================================================
  // edge detection
  logic prev_r;
  logic latch_r;
  logic latch_nxt;
  logic rise;
  logic fall;
  logic edgeHit;
  logic lowHold;

  assign rise = pinLevel & ~prev_r;
  assign fall = ~pinLevel & prev_r;

  // a pin switch can look like an edge; software should reprogram with the mask set
  assign edgeHit = lineEn & (
    ((senseCode == ewp_pkg::SENSE_FALL_LOW) & fall) |
    ((senseCode == ewp_pkg::SENSE_RISE)     & rise) |
    ((senseCode == ewp_pkg::SENSE_FALL)     & fall) |
    ((senseCode == ewp_pkg::SENSE_BOTH)     & (rise | fall)));

  // new edge beats a clear in the same cycle
  assign latch_nxt = edgeHit ? 1'b1 : (serviceAck ? 1'b0 : latch_r);

  // level request survives the clear while the pin stays low
  assign lowHold = lineEn & (senseCode == ewp_pkg::SENSE_FALL_LOW) & ~pinLevel;

  assign lineReq = latch_r | lowHold;

  // ==========================================================================
  // state
  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      prev_r  <= 1'b1;
      latch_r <= 1'b0;
    end else if (clkEn) begin
      prev_r  <= pinLevel;
      latch_r <= latch_nxt;
    end
  end

endmodule : ewp_ext_line

//--- rtl/ewp_ctrl.sv
// external wake-line configuration and power-mode controller, top level
// Function
// - sensitivity register: four two-bit line fields
// - decode falling-low, rising, falling, both edges
// - sensitivity writes only while mask set
// - line 3 selects none, B0, B1, B2
// - line 2 selects none, B3, B5, B6
// - line 1 selects none, A4, A5, A6
// - line 0 selects none, A1, A2, A3
// - reset enters run at master clock
// - slow select divides oscillator by 32
// - wait while slow keeps slow peripheral clock
// - wait stops cpu, peripherals keep running
// - wait clears mask, nothing else changes
// - wait ends on any interrupt or reset
// - halt only without active-halt and auto-wakeup
// - halt exit: 256-cycle oscillator start-up
// - halt entry clears mask; pending wakes immediately
// - halt stops oscillator and all clocks
// - watchdog option may turn halt into reset
// - servicing pushes mask, sets it, pop restores
// - edge requests latched, cleared on service
// - vector only when pending and mask clear
// - any external line wakes from halt
//
// Decided for this implementation: strobed register access and the placing of the registers.
module ewp_ctrl (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       clkEn,
  input  wire logic [1:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrStrobe,
  input  wire logic       regRdStrobe,
  output logic      [7:0] regRdData,
  input  wire logic [7:0] portA,
  input  wire logic [7:0] portB,
  input  wire logic       waitInstr,
  input  wire logic       haltInstr,
  input  wire logic       maskSetSw,
  input  wire logic       maskClrSw,
  input  wire logic       ccPop,
  input  wire logic       popMaskVal,
  input  wire logic [3:0] vectorAck,
  input  wire logic       otherIrq,
  input  wire logic       haltWakeIrq,
  input  wire logic       activeHaltEn,
  input  wire logic       wdgEnabled,
  input  wire logic       wdgHaltOpt,
  output logic      [3:0] irqReq,
  output logic            imaskOut,
  output logic            pushedMask,
  output logic            cpuClkEn,
  output logic            periphClkEn,
  output logic            oscEnable,
  output logic            wdgResetReq,
  output logic      [2:0] powerState
);

  // ==========================================================================
  // reset release
  logic [1:0] rstPipe_r;
  logic       rstSync_b;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe_r <= 2'b00;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end

  assign rstSync_b = rstPipe_r[1];

  // ==========================================================================
  // registers and decode
  logic [7:0]          sense_r;
  logic [7:0]          pinSel_r;
  logic [1:0]          pwrCtrl_r;
  logic                imask_r;
  logic                imask_nxt;
  logic                pushedMask_r;
  logic [7:0]          rdData_r;
  logic [7:0]          rdMux;
  logic [7:0]          statusWord;
  logic                senseWr;
  logic                pinSelWr;
  logic                pwrCtrlWr;
  logic [3:0]          lineReq;
  ewp_pkg::ewp_state_e state_r;
  ewp_pkg::ewp_state_e state_nxt;

  // reprogramming sensitivity is only safe with interrupts masked
  assign senseWr   = regWrStrobe & (regAddr == ewp_pkg::ADDR_SENSE) & imask_r;
  assign pinSelWr  = regWrStrobe & (regAddr == ewp_pkg::ADDR_PINSEL);
  assign pwrCtrlWr = regWrStrobe & (regAddr == ewp_pkg::ADDR_PWRCTRL);

  assign statusWord = {lineReq, imask_r, state_r};

  assign rdMux =
    (regAddr == ewp_pkg::ADDR_SENSE)   ? sense_r :
    (regAddr == ewp_pkg::ADDR_PINSEL)  ? pinSel_r :
    (regAddr == ewp_pkg::ADDR_PWRCTRL) ? {6'h00, pwrCtrl_r} :
                                         statusWord;

  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      sense_r   <= ewp_pkg::SENSE_RESET;
      pinSel_r  <= ewp_pkg::PINSEL_RESET;
      pwrCtrl_r <= ewp_pkg::PWRCTRL_RESET;
      rdData_r  <= 8'h00;
    end else if (clkEn) begin
      if (senseWr) begin
        sense_r <= regWrData;
      end
      if (pinSelWr) begin
        pinSel_r <= regWrData;
      end
      if (pwrCtrlWr) begin
        pwrCtrl_r <= regWrData[1:0];
      end
      rdData_r <= regRdStrobe ? rdMux : 8'h00;
    end
  end

  assign regRdData = rdData_r;

  // ==========================================================================
  // external lines
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_line
      logic [1:0] pinCode;
      logic [2:0] pinIdx;
      logic [7:0] srcPort;
      logic       lineEn;
      logic       pinLevel;

      assign pinCode = pinSel_r[gi*ewp_pkg::FIELD_W +: ewp_pkg::FIELD_W];
      assign lineEn  = (pinCode != ewp_pkg::PIN_NONE);
      assign srcPort = ewp_pkg::LINE_ON_PORTB[gi] ? portB : portA;
      assign pinIdx  = lineEn ? ewp_pkg::LINE_PIN[gi][pinCode - 2'h1] : 3'h0;
      // an unrouted line reads high so it cannot raise a level request
      assign pinLevel = lineEn ? srcPort[pinIdx] : 1'b1;

      ewp_ext_line u_line (
        .mclk       (mclk),
        .rstSync_b  (rstSync_b),
        .clkEn      (clkEn),
        .lineEn     (lineEn),
        .pinLevel   (pinLevel),
        .senseCode  (sense_r[gi*ewp_pkg::FIELD_W +: ewp_pkg::FIELD_W]),
        .serviceAck (vectorAck[gi]),
        .lineReq    (lineReq[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // interrupt mask
  logic anyAck;
  logic enterWait;
  logic enterHalt;
  logic maskClr;

  assign anyAck  = |vectorAck;
  assign maskClr = maskClrSw | enterHalt | (state_r == ewp_pkg::PWR_WAIT) | enterWait;

  // entering a routine sets the mask and wins over any clear
  assign imask_nxt = (anyAck | maskSetSw) ? 1'b1 :
                     ccPop                ? popMaskVal :
                     maskClr              ? 1'b0 : imask_r;

  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      imask_r      <= ewp_pkg::IMASK_RESET;
      pushedMask_r <= ewp_pkg::IMASK_RESET;
    end else if (clkEn) begin
      imask_r <= imask_nxt;
      if (anyAck) begin
        pushedMask_r <= imask_r;
      end
    end
  end

  assign imaskOut   = imask_r;
  assign pushedMask = pushedMask_r;
  assign irqReq     = lineReq & {4{~imask_r & (state_r == ewp_pkg::PWR_RUN)}};

  // ==========================================================================
  // power-mode sequencer
  logic       haltAllowed;
  logic       wdgHaltReset;
  logic       anyIrq;
  logic       haltWake;
  logic       startDone;
  logic [8:0] startCnt_r;
  logic       wdgResetReq_r;

  assign haltAllowed  = ~activeHaltEn & ~pwrCtrl_r[ewp_pkg::AWU_EN_BIT];
  // option low: halting with the watchdog running resets instead
  assign wdgHaltReset = haltInstr & wdgEnabled & ~wdgHaltOpt;
  assign enterWait    = (state_r == ewp_pkg::PWR_RUN) & waitInstr & ~haltInstr;
  assign enterHalt    = (state_r == ewp_pkg::PWR_RUN) & haltInstr & haltAllowed
                        & ~wdgHaltReset;
  assign anyIrq       = (|lineReq) | otherIrq;
  assign haltWake     = (|lineReq) | haltWakeIrq;
  assign startDone    = (startCnt_r == ewp_pkg::STARTUP_LAST);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ewp_pkg::PWR_RUN: begin
        if (enterHalt) begin
          state_nxt = ewp_pkg::PWR_HALT;
        end else if (enterWait) begin
          state_nxt = ewp_pkg::PWR_WAIT;
        end
      end
      ewp_pkg::PWR_WAIT: begin
        if (anyIrq) begin
          state_nxt = ewp_pkg::PWR_RUN;
        end
      end
      ewp_pkg::PWR_HALT: begin
        // a request already pending leaves on the very next edge
        if (haltWake) begin
          state_nxt = ewp_pkg::PWR_STARTUP;
        end
      end
      ewp_pkg::PWR_STARTUP: begin
        if (startDone) begin
          state_nxt = ewp_pkg::PWR_RUN;
        end
      end
      default: begin
        state_nxt = ewp_pkg::PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      state_r       <= ewp_pkg::PWR_RUN;
      startCnt_r    <= 9'h000;
      wdgResetReq_r <= 1'b0;
    end else if (clkEn) begin
      state_r       <= state_nxt;
      startCnt_r    <= (state_r == ewp_pkg::PWR_STARTUP) ? startCnt_r + 9'h001 : 9'h000;
      wdgResetReq_r <= (state_r == ewp_pkg::PWR_RUN) & wdgHaltReset;
    end
  end

  assign wdgResetReq = wdgResetReq_r;
  assign powerState  = state_r;

  // ==========================================================================
  // clock enables
  logic       slowSel;
  logic [4:0] slowCnt_r;
  logic       masterTick;

  assign slowSel = pwrCtrl_r[ewp_pkg::SLOW_SEL_BIT];

  // divider free-runs while slow so the wait state keeps the same rate
  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      slowCnt_r <= 5'h00;
    end else if (clkEn) begin
      if (!slowSel || slowCnt_r == ewp_pkg::SLOW_LAST) begin
        slowCnt_r <= 5'h00;
      end else begin
        slowCnt_r <= slowCnt_r + 5'h01;
      end
    end
  end

  assign masterTick  = ~slowSel | (slowCnt_r == ewp_pkg::SLOW_LAST);
  assign cpuClkEn    = clkEn & masterTick & (state_r == ewp_pkg::PWR_RUN);
  assign periphClkEn = clkEn & masterTick
                       & ((state_r == ewp_pkg::PWR_RUN) | (state_r == ewp_pkg::PWR_WAIT));
  assign oscEnable   = (state_r != ewp_pkg::PWR_HALT);

endmodule : ewp_ctrl

//--- sim/ewp_ctrl_sva.sv
// port-level assertions for the wake-line and power-mode controller
module ewp_ctrl_sva (
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       clkEn,
  input wire logic       regRdStrobe,
  input wire logic [7:0] regRdData,
  input wire logic       waitInstr,
  input wire logic       haltInstr,
  input wire logic [3:0] vectorAck,
  input wire logic       otherIrq,
  input wire logic [3:0] irqReq,
  input wire logic       imaskOut,
  input wire logic       cpuClkEn,
  input wire logic       oscEnable,
  input wire logic [2:0] powerState
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // checks
  // a frozen clock stalls every count, so a low enable abandons the attempt
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b || !clkEn);
  wire logic isRun   = powerState == ewp_pkg::PWR_RUN;
  wire logic isWait  = powerState == ewp_pkg::PWR_WAIT;
  wire logic isHalt  = powerState == ewp_pkg::PWR_HALT;
  wire logic isStart = powerState == ewp_pkg::PWR_STARTUP;
  sequence s_left_halt;
    $fell(isHalt) && isStart;
  endsequence
  sequence s_startup;
    ##255 isStart ##1 isRun;
  endsequence
  a_rd_idle: assert property (!$past(regRdStrobe) |-> regRdData == 8'h00)
    else $error("read data outside its slot");
  a_halt_dark: assert property (isHalt |-> !oscEnable && !cpuClkEn && !imaskOut)
    else $error("halt left clocks or mask on");
  a_mask_blocks: assert property (imaskOut || !isRun |-> irqReq == 4'h0)
    else $error("request passed a closed mask");
  a_wait_entry: assert property (isRun && waitInstr && !haltInstr |=> isWait)
    else $error("wait not entered");
  a_wait_open: assert property (isWait |-> !imaskOut && !cpuClkEn)
    else $error("wait kept mask or cpu clock");
  a_wait_exit: assert property (isWait && otherIrq |=> isRun)
    else $error("wait ignored a request");
  a_ack_masks: assert property (isRun && |vectorAck && !waitInstr && !haltInstr |=> imaskOut)
    else $error("service entry left mask clear");
  a_startup_len: assert property (s_left_halt |-> s_startup)
    else $error("start-up delay not 256 cycles");
endmodule : ewp_ctrl_sva

bind ewp_ctrl ewp_ctrl_sva i_ewp_ctrl_sva (.*);

//--- sim/ewp_pin_model.sv
// pin-level model of the port lines that feed the wake inputs
module ewp_pin_model (
  input  wire logic [15:0] pinLevels,
  output logic      [7:0]  portA,
  output logic      [7:0]  portB
);
  timeunit 1ns;
  timeprecision 100ps;
  // pins are driven push-pull by the far side, so no released state exists
  assign portA = pinLevels[7:0];
  assign portB = pinLevels[15:8];
endmodule : ewp_pin_model

//--- sim/test_ewp_ctrl.sv
// self-checking bench for the wake-line and power-mode controller
module test_ewp_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // wiring
  logic        mclk = 1'b0, rstB = 1'b0, clkEn = 1'b1, wrS = 1'b0, rdS = 1'b0;
  logic        waitI = 1'b0, haltI = 1'b0, mSet = 1'b0, mClr = 1'b0, other = 1'b0;
  logic        aHalt = 1'b0, wdgEn = 1'b0, wdgOpt = 1'b1;
  logic        pop = 1'b0, popV = 1'b0, hWake = 1'b0;
  localparam int PSET  = 0;
  localparam int PCLR  = 1;
  localparam int PWAIT = 2;
  localparam int PHALT = 3;
  logic [1:0]  addr = 2'h0;
  logic [7:0]  wdat = 8'h00;
  logic [3:0]  ack = 4'h0;
  logic [15:0] pins = 16'h0000;
  wire logic [7:0] rdat, portA, portB;
  wire logic [3:0] irq;
  wire logic [2:0] pst;
  wire logic       imask, pushed, cpuEn, perEn, osc, wdgRst;
  int              nFail = 0, samplesChecked = 0;
  int              pinTab [4][3] = '{'{1, 2, 3}, '{4, 5, 6}, '{3, 5, 6}, '{0, 1, 2}};
  ewp_pin_model i_ewp_pin_model (.pinLevels(pins), .portA(portA), .portB(portB));
  ewp_ctrl i_ewp_ctrl (.mclk(mclk), .rst_b(rstB), .clkEn(clkEn), .regAddr(addr),
    .regWrData(wdat), .regWrStrobe(wrS), .regRdStrobe(rdS), .regRdData(rdat), .portA(portA),
    .portB(portB), .waitInstr(waitI), .haltInstr(haltI), .maskSetSw(mSet), .maskClrSw(mClr),
    .ccPop(pop), .popMaskVal(popV), .vectorAck(ack), .otherIrq(other), .haltWakeIrq(hWake),
    .activeHaltEn(aHalt), .wdgEnabled(wdgEn), .wdgHaltOpt(wdgOpt), .irqReq(irq),
    .imaskOut(imask), .pushedMask(pushed), .cpuClkEn(cpuEn), .periphClkEn(perEn),
    .oscEnable(osc), .wdgResetReq(wdgRst), .powerState(pst));
  // ==========================================================================
  // shared tasks
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    samplesChecked++;
    if (seen !== exp) begin
      nFail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one-cycle pulse on a cpu-side strobe chosen by code
  task automatic pulse(input int w);
    @(posedge mclk) begin
      case (w)
        PSET: mSet <= 1'b1;
        PCLR: mClr <= 1'b1;
        PWAIT: waitI <= 1'b1;
        default: haltI <= 1'b1;
      endcase
    end
    @(posedge mclk) begin
      mSet <= 1'b0;
      mClr <= 1'b0;
      waitI <= 1'b0;
      haltI <= 1'b0;
    end
  endtask : pulse
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk) begin addr <= a; wdat <= d; wrS <= 1'b1; end
    @(posedge mclk) wrS <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [1:0] a, input logic [7:0] e, input string nm);
    @(posedge mclk) begin addr <= a; rdS <= 1'b1; end
    @(posedge mclk) rdS <= 1'b0;
    #1 chk(nm, rdat, e);
  endtask : rdc
  task automatic ackLine(input logic [3:0] v);
    @(posedge mclk) ack <= v;
    @(posedge mclk) ack <= 4'h0;
  endtask : ackLine
  // counts clock enables over 32 cycles; one window fits two slow ticks exactly
  task automatic slow32(output int nc, output int np);
    nc = 0;
    np = 0;
    repeat (32) begin
      @(posedge mclk);
      #1 nc += int'(cpuEn);
      np += int'(perEn);
    end
  endtask : slow32
  task automatic close_out();
    $display("checks %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // ==========================================================================
  // scenarios
  task automatic t_regs();
    rdc(2'h0, 8'h00, "sense reset");
    rdc(2'h1, 8'h00, "pinsel reset");
    rdc(2'h2, 8'h00, "power reset");
    rdc(2'h3, 8'h08, "status reset");
    wr(2'h3, 8'hff);
    rdc(2'h3, 8'h08, "status read-only");
    pulse(PCLR);
    wr(2'h0, 8'h55);
    rdc(2'h0, 8'h00, "sense locked");
    pulse(PSET);
    wr(2'h0, 8'h55);
    rdc(2'h0, 8'h55, "sense open");
  endtask : t_regs
  task automatic t_route();
    int idx;
    for (int l = 0; l < 4; l++) begin
      for (int c = 1; c < 4; c++) begin
        idx = pinTab[l][c - 1] + (l > 1 ? 8 : 0);
        wr(2'h1, 8'(c << (2 * l)));
        pulse(PCLR);
        @(posedge mclk) pins[idx] <= 1'b1;
        tick(2);
        #1 chk("routed line", {12'h0, irq}, 16'(1 << l));
        @(posedge mclk) begin ack <= 4'(1 << l); pins <= 16'h0000; end
        @(posedge mclk) ack <= 4'h0;
        #1 chk("service entry", {imask, pushed, 2'h0, irq}, 16'h0080);
      end
    end
  endtask : t_route
  task automatic t_sense();
    wr(2'h1, 8'h01);
    for (int c = 0; c < 4; c++) begin
      pulse(PSET);
      wr(2'h0, 8'(c));
      @(posedge mclk) pins[1] <= 1'b1;
      ackLine(4'h1);
      pulse(PCLR);
      @(posedge mclk) pins[1] <= 1'b0;
      tick(2);
      #1 chk("falling", {15'h0, irq[0]}, 16'(c != 1));
      ackLine(4'h1);
      pulse(PCLR);
      tick(1);
      #1 chk("low hold", {15'h0, irq[0]}, 16'(c == 0));
      @(posedge mclk) pins[1] <= 1'b1;
      tick(2);
      #1 chk("rising", {15'h0, irq[0]}, 16'(c % 2));
    end
    ackLine(4'h1);
  endtask : t_sense
  task automatic t_wait();
    int nc, np;
    wr(2'h2, 8'h01);
    slow32(nc, np);
    chk("slow clock", 16'(nc), 16'd2);
    pulse(PWAIT);
    #1 chk("wait entry", {imask, 12'h0, pst}, 16'h0001);
    slow32(nc, np);
    chk("slow wait", 16'(nc + 4 * np), 16'd8);
    rdc(2'h1, 8'h01, "wait keeps regs");
    @(posedge mclk) other <= 1'b1;
    tick(2);
    #1 chk("wait exit", {13'h0, pst}, 16'h0000);
    @(posedge mclk) other <= 1'b0;
    wr(2'h2, 8'h00);
    slow32(nc, np);
    chk("run clock", 16'(nc), 16'd32);
  endtask : t_wait
  task automatic t_halt();
    int n, ns;
    pulse(PSET);
    wr(2'h0, 8'h01);
    @(posedge mclk) begin pins[1] <= 1'b0; aHalt <= 1'b1; end
    pulse(PHALT);
    #1 chk("active halt", {13'h0, pst}, 16'h0000);
    @(posedge mclk) aHalt <= 1'b0;
    wr(2'h2, 8'h02);
    pulse(PHALT);
    #1 chk("auto wake", {13'h0, pst}, 16'h0000);
    wr(2'h2, 8'h00);
    @(posedge mclk) begin wdgEn <= 1'b1; wdgOpt <= 1'b0; end
    pulse(PHALT);
    #1 chk("wdg halt", {wdgRst, 12'h0, pst}, 16'h8000);
    @(posedge mclk) wdgOpt <= 1'b1;
    pulse(PHALT);
    #1 chk("halt", {imask, osc, cpuEn, perEn, 9'h0, pst}, 16'h0002);
    @(posedge mclk) pins[1] <= 1'b1;
    n = 0;
    ns = 0;
    do begin
      @(posedge mclk);
      #1 ns += int'(pst == 3'h3);
      n++;
    end while (pst !== 3'h0 && n < 400);
    if (n >= 400) begin
      nFail++;
      close_out();
    end else begin
      chk("start-up", 16'(ns), 16'd256);
      chk("wake service", {15'h0, irq[0]}, 16'h0001);
    end
  endtask : t_halt
  task automatic t_misc();
    // stacked mask comes back on return from the routine
    @(posedge mclk) begin pop <= 1'b1; popV <= 1'b0; end
    @(posedge mclk) pop <= 1'b0;
    #1 chk("pop restore", {15'h0, imask}, 16'h0000);
    // a low enable freezes the port, so this write must not land
    @(posedge mclk) clkEn <= 1'b0;
    wr(2'h1, 8'h00);
    @(posedge mclk) clkEn <= 1'b1;
    rdc(2'h1, 8'h01, "frozen write");
    // a non-line halt wake source starts the oscillator too
    ackLine(4'h1);
    pulse(PHALT);
    @(posedge mclk) hWake <= 1'b1;
    tick(1);
    #1 chk("other wake", {13'h0, pst}, 16'h0003);
    @(posedge mclk) hWake <= 1'b0;
    tick(260);
    #1 chk("other wake run", {13'h0, pst}, 16'h0000);
    // reset in mid-run returns every register to its reset value
    @(posedge mclk) rstB <= 1'b0;
    tick(2);
    @(posedge mclk) rstB <= 1'b1;
    tick(3);
    rdc(2'h1, 8'h00, "pinsel re-reset");
    rdc(2'h3, 8'h08, "status re-reset");
  endtask : t_misc
  // ==========================================================================
  // run
  initial begin
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (20) @(posedge mclk);
    rstB <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs();
    t_route();
    t_sense();
    t_wait();
    t_halt();
    t_misc();
    close_out();
  end
endmodule : test_ewp_ctrl
